// ===== core/ppeiu_pkg.sv
`default_nettype none
package ppeiu_pkg;
	// register byte offsets
	localparam logic [5:0] OFF_EDGE_SEL0 = 6'h00;
	localparam logic [5:0] OFF_EVENT_FLAGS = 6'h20;
	localparam logic [5:0] OFF_SNAPSHOT = 6'h24;
	localparam logic [5:0] OFF_PIN_LEVEL = 6'h28;
	localparam int NUM_PINS = 8;
	localparam int EDGE_SEL_W = 2;
	localparam logic [1:0] EDGE_SEL_RESET = 2'h0;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] SNAP_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		PPEIU_EDGE_NONE = 2'h0,
		PPEIU_EDGE_RISE = 2'h1,
		PPEIU_EDGE_FALL = 2'h2,
		PPEIU_EDGE_BOTH = 2'h3
	} ppeiu_edge_t;

	typedef struct packed {
		logic [1:0] resp;
		logic [31:0] data;
	} ppeiu_rd_t;
endpackage
`default_nettype wire

// ===== core/ppeiu_port_irq_unit.sv
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - each pin has its own edge select: rising, falling or either.
// - no level-sensitive detection; only edges create events.
// - a selected edge sets that pin's flag and requests an interrupt.
// - reading the flag register clears every flag that read as one.
// - flags reading zero keep capturing edges during and after the read.
// - during a read, new edges on already-pending pins are ignored.
// - during a read, non-pending pins still set on a selected edge.
// - wake output is wake input ORed with own pin events.
// - units chain wake out to next wake in; last goes to power manager.
// - pad state is untouched by sleep; this unit never drives pads.
// - detection keeps running in sleep modes to allow wake.
// - interrupt logic works in all low-power modes.
// - all pin events combine into one interrupt request output.
// - one unit serves eight pins with one interrupt output.
// - interrupt generation is enabled per pin.
// - the flag register holds one bit per pin.
// - each flag read captures pin levels into a snapshot register.
// - one edge select register per pin, one flag and one snapshot register.
// - registers are reached through the bus hub interface.
module ppeiu_port_irq_unit (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] pin_in,
	input wire logic wake_in,
	output logic wake_out,
	output logic port_combined_irq,
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ********************************
	// pin sampling and edge detection
	// ********************************
	// one clock, no gating: keeps detecting in every sleep mode
	logic [7:0] sync1;
	logic [7:0] sync2;
	logic [7:0] prev;
	logic [1:0] edge_sel [8];
	logic [7:0] event_hit;
	logic [7:0] flags;
	logic [7:0] snapshot;

	// pins are inputs only, so pad state is never touched here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1 <= 8'h00;
			sync2 <= 8'h00;
			prev <= 8'h00;
		end else begin
			sync1 <= pin_in;
			sync2 <= sync1;
			prev <= sync2;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < ppeiu_pkg::NUM_PINS; gi++) begin : g_pin
			logic rise;
			logic fall;
			assign rise = sync2[gi] & ~prev[gi];
			assign fall = ~sync2[gi] & prev[gi];
			// edge only, per pin, none means disabled
			assign event_hit[gi] =
				(edge_sel[gi] == ppeiu_pkg::PPEIU_EDGE_RISE && rise) ||
				(edge_sel[gi] == ppeiu_pkg::PPEIU_EDGE_FALL && fall) ||
				(edge_sel[gi] == ppeiu_pkg::PPEIU_EDGE_BOTH && (rise | fall));
		end
	endgenerate

	// ********************************
	// bus slave: write channel
	// ********************************
	logic aw_held;
	logic w_held;
	logic [5:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 6'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ppeiu_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr[5] == 1'b0 && aw_addr[1:0] == 2'h0) ?
					ppeiu_pkg::RESP_OKAY : ppeiu_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// one edge select register per pin, word 0..7
	generate
		for (gi = 0; gi < ppeiu_pkg::NUM_PINS; gi++) begin : g_sel
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					edge_sel[gi] <= ppeiu_pkg::EDGE_SEL_RESET;
				end else if (do_write && w_strb[0] && aw_addr[1:0] == 2'h0
					&& aw_addr[5:2] == 4'(gi)) begin
					edge_sel[gi] <= w_data[1:0];
				end
			end
		end
	endgenerate

	// ********************************
	// bus slave: read channel
	// ********************************
	logic flag_read;
	logic [7:0] next_flags;
	logic [31:0] rd_word;
	ppeiu_pkg::ppeiu_rd_t rd;

	always_comb begin
		rd.resp = ppeiu_pkg::RESP_OKAY;
		rd.data = 32'h0000_0000;
		rd_word = 32'h0000_0000;
		if (s_axi_araddr[1:0] != 2'h0) begin
			rd.resp = ppeiu_pkg::RESP_SLVERR;
		end else if (s_axi_araddr[5] == 1'b0) begin
			rd_word[1:0] = edge_sel[s_axi_araddr[4:2]];
			rd.data = rd_word;
		end else begin
			case (s_axi_araddr)
				ppeiu_pkg::OFF_EVENT_FLAGS: rd.data = {24'h000000, flags};
				ppeiu_pkg::OFF_SNAPSHOT: rd.data = {24'h000000, snapshot};
				ppeiu_pkg::OFF_PIN_LEVEL: rd.data = {24'h000000, sync2};
				default: rd.resp = ppeiu_pkg::RESP_SLVERR;
			endcase
		end
	end

	assign flag_read = s_axi_arvalid && s_axi_arready
		&& s_axi_araddr == ppeiu_pkg::OFF_EVENT_FLAGS;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= ppeiu_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd.data;
				s_axi_rresp <= rd.resp;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ********************************
	// event flags and snapshot
	// ********************************
	// the read is the single address-accept cycle, so the returned word and
	// the clear see the same flags; pending pins drop new edges that cycle
	always_comb begin
		if (flag_read) begin
			// clear what read as one, pending edges blocked
			// zero bits still capture
			next_flags = event_hit & ~flags;
		end else begin
			next_flags = flags | event_hit;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags <= ppeiu_pkg::FLAGS_RESET;
		end else begin
			flags <= next_flags;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			snapshot <= ppeiu_pkg::SNAP_RESET;
		end else if (flag_read) begin
			snapshot <= sync2;
		end
	end

	// ********************************
	// request and wake outputs
	// ********************************
	// registered: wake_out lags event_hit by one cycle, port_combined_irq rises with the flags; keeps outputs glitch free
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_combined_irq <= 1'b0;
			wake_out <= 1'b0;
		end else begin
			port_combined_irq <= |next_flags;
			wake_out <= wake_in | (|event_hit);
		end
	end

	// ********************************
	// assertions
	// ********************************
	property p_set_on_edge;
		@(posedge aclk) disable iff (!aresetn)
		(event_hit != 8'h00 && !flag_read) |=> ((flags & $past(event_hit)) == $past(event_hit));
	endproperty
	a_set_on_edge: assert property (p_set_on_edge)
		else $error("edge did not set flag");

	property p_clear_on_read;
		@(posedge aclk) disable iff (!aresetn)
		flag_read |=> ((flags & $past(flags)) == 8'h00);
	endproperty
	a_clear_on_read: assert property (p_clear_on_read)
		else $error("pending flag not cleared");

	property p_capture_during_read;
		@(posedge aclk) disable iff (!aresetn)
		flag_read |=> ((flags & ~$past(flags)) == ($past(event_hit) & ~$past(flags)));
	endproperty
	a_capture_during_read: assert property (p_capture_during_read)
		else $error("idle pin lost event");

	property p_rdata_flags;
		@(posedge aclk) disable iff (!aresetn)
		flag_read |=> (s_axi_rvalid && s_axi_rdata[7:0] == $past(flags));
	endproperty
	a_rdata_flags: assert property (p_rdata_flags)
		else $error("flag read data wrong");

	property p_snapshot;
		@(posedge aclk) disable iff (!aresetn)
		flag_read |=> (snapshot == $past(sync2));
	endproperty
	a_snapshot: assert property (p_snapshot)
		else $error("snapshot not captured");

	property p_irq_tracks;
		@(posedge aclk) disable iff (!aresetn)
		##1 (port_combined_irq == (flags != 8'h00));
	endproperty
	a_irq_tracks: assert property (p_irq_tracks)
		else $error("irq mismatch with flags");

	property p_wake;
		@(posedge aclk) disable iff (!aresetn)
		(wake_in || event_hit != 8'h00) |=> wake_out;
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake not raised");

	property p_none_disabled;
		@(posedge aclk) disable iff (!aresetn)
		(edge_sel[0] == ppeiu_pkg::PPEIU_EDGE_NONE) |-> !event_hit[0];
	endproperty
	a_none_disabled: assert property (p_none_disabled)
		else $error("disabled pin fired");

	property p_rise_only;
		@(posedge aclk) disable iff (!aresetn)
		(edge_sel[1] == ppeiu_pkg::PPEIU_EDGE_RISE && $fell(sync2[1])) |-> !event_hit[1];
	endproperty
	a_rise_only: assert property (p_rise_only)
		else $error("rise mode hit on fall");

	property p_fall_only;
		@(posedge aclk) disable iff (!aresetn)
		(edge_sel[2] == ppeiu_pkg::PPEIU_EDGE_FALL && $rose(sync2[2])) |-> !event_hit[2];
	endproperty
	a_fall_only: assert property (p_fall_only)
		else $error("fall mode hit on rise");

	property p_both_edges;
		@(posedge aclk) disable iff (!aresetn)
		(edge_sel[3] == ppeiu_pkg::PPEIU_EDGE_BOTH && sync2[3] != prev[3]) |-> event_hit[3];
	endproperty
	a_both_edges: assert property (p_both_edges)
		else $error("either-edge mode missed an edge");

	property p_block_pending;
		@(posedge aclk) disable iff (!aresetn)
		(flag_read && (flags & event_hit) != 8'h00) |=>
			((flags & $past(flags & event_hit)) == 8'h00);
	endproperty
	a_block_pending: assert property (p_block_pending)
		else $error("pending pin not blocked during read");

	property p_keep_flag;
		@(posedge aclk) disable iff (!aresetn)
		!flag_read |=> ((flags & $past(flags)) == $past(flags));
	endproperty
	a_keep_flag: assert property (p_keep_flag)
		else $error("flag dropped without a read");

	property p_no_spurious;
		@(posedge aclk) disable iff (!aresetn)
		(event_hit == 8'h00) |=> ((flags & ~$past(flags)) == 8'h00);
	endproperty
	a_no_spurious: assert property (p_no_spurious)
		else $error("flag set without an edge");

	property p_wake_quiet;
		@(posedge aclk) disable iff (!aresetn)
		(!wake_in && event_hit == 8'h00) |=> !wake_out;
	endproperty
	a_wake_quiet: assert property (p_wake_quiet)
		else $error("wake raised without a source");

	property p_sel_write;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && w_strb[0] && aw_addr == ppeiu_pkg::OFF_EDGE_SEL0) |=>
			(edge_sel[0] == $past(w_data[1:0]));
	endproperty
	a_sel_write: assert property (p_sel_write)
		else $error("edge select write lost");

	property p_bvalid_hold;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp));
	endproperty
	a_bvalid_hold: assert property (p_bvalid_hold)
		else $error("write response dropped early");

	property p_rvalid_hold;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata));
	endproperty
	a_rvalid_hold: assert property (p_rvalid_hold)
		else $error("read data dropped early");

	c_read_flags: cover property (@(posedge aclk) disable iff (!aresetn)
		flag_read && flags != 8'h00);
	c_edge_in_read: cover property (@(posedge aclk) disable iff (!aresetn)
		flag_read && event_hit != 8'h00);
	c_blocked: cover property (@(posedge aclk) disable iff (!aresetn)
		flag_read && (flags & event_hit) != 8'h00);
	c_write: cover property (@(posedge aclk) disable iff (!aresetn)
		do_write);
	c_wake: cover property (@(posedge aclk) disable iff (!aresetn)
		wake_out && !wake_in);
endmodule
`default_nettype wire

// ===== testbench/ppeiu_wake_chain_model.sv
`timescale 1ns/100ps
`default_nettype none
module ppeiu_wake_chain_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic up_wake,
	input wire logic pm_clear,
	input wire logic wake_back,
	output logic wake_to_unit,
	output logic pm_wake
);
	// upstream unit, registered like a real chained unit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_to_unit <= 1'b0;
		end else begin
			wake_to_unit <= up_wake;
		end
	end
	// power manager holds the wake, else a one-cycle pulse is lost
	always_ff @(posedge aclk) begin
		if (!aresetn || pm_clear) begin
			pm_wake <= 1'b0;
		end else if (wake_back) begin
			pm_wake <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/port_pin_edge_interrupt_unit_tb.sv
`timescale 1ns/100ps
`default_nettype none
module port_pin_edge_interrupt_unit_tb;
	logic aclk, aresetn, up_wake, pm_clear, wake_in, wake_out, port_combined_irq, pm_wake;
	logic [7:0] pin_in, v0, v1, e;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [15:0] lfsr, s;
	int n_fail, tests_run, cyc;
	ppeiu_pkg::ppeiu_rd_t rq[$], re;
	logic [1:0] bq[$];

	ppeiu_port_irq_unit u_ppeiu_port_irq_unit (.aclk, .aresetn, .pin_in, .wake_in, .wake_out,
		.port_combined_irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	ppeiu_wake_chain_model u_ppeiu_wake_chain_model (.aclk, .aresetn, .up_wake, .pm_clear,
		.wake_back(wake_out), .wake_to_unit(wake_in), .pm_wake);

	// ************************
	// clock, timeout, verdict
	// ************************
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	task test_done;
		if (n_fail == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// whole run needs about 900 cycles
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			test_done();
		end
	end
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function logic [15:0] nxt(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function logic [7:0] want(input logic [15:0] sel, input logic [7:0] a, input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			case (sel[2*i+:2])
				ppeiu_pkg::PPEIU_EDGE_RISE: want[i] = b[i] & ~a[i];
				ppeiu_pkg::PPEIU_EDGE_FALL: want[i] = a[i] & ~b[i];
				ppeiu_pkg::PPEIU_EDGE_BOTH: want[i] = a[i] ^ b[i];
				default: want[i] = 1'b0;
			endcase
		end
	endfunction

	// ************************
	// bus master and monitor
	// ************************
	task wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
		bq.push_back(er);
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
		rq.push_back('{er, d});
		@(posedge aclk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask
	task set_sel(input logic [15:0] sv);
		for (int i = 0; i < 8; i++) wr(6'(4 * i), {30'h0, sv[2*i+:2]}, ppeiu_pkg::RESP_OKAY);
	endtask
	always @(posedge aclk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
			re = rq.pop_front();
			check("rresp", s_axi_rresp, re.resp);
			check("rdata", s_axi_rdata, re.data);
		end
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
			check("bresp", s_axi_bresp, bq.pop_front());
		end
	end

	// ************************
	// scenarios
	// ************************
	initial begin
		{aresetn, up_wake, pm_clear, pin_in, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		{n_fail, tests_run, cyc} = '0;
		lfsr = 16'hA685;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ppeiu_pkg::OFF_EVENT_FLAGS, 32'h0, ppeiu_pkg::RESP_OKAY);
		rd(ppeiu_pkg::OFF_SNAPSHOT, 32'h0, ppeiu_pkg::RESP_OKAY);
		rd(6'h2C, 32'h0, ppeiu_pkg::RESP_SLVERR);
		wr(6'h30, 32'h1, ppeiu_pkg::RESP_SLVERR);
		wr(6'h02, 32'h1, ppeiu_pkg::RESP_SLVERR);
		wr(6'h08, 32'h3, ppeiu_pkg::RESP_OKAY);
		rd(6'h08, 32'h3, ppeiu_pkg::RESP_OKAY);
		wr(6'h08, 32'h0, ppeiu_pkg::RESP_OKAY);
		@(posedge aclk) up_wake <= 1'b1;
		repeat (4) @(negedge aclk);
		check("wake_out", wake_out, 32'h1);
		check("pm_wake", pm_wake, 32'h1);
		@(posedge aclk) up_wake <= 1'b0;
		repeat (3) @(posedge aclk);
		for (int r = 0; r < 8; r++) begin
			// new levels with every pin off: nothing may be recorded
			lfsr = nxt(lfsr);
			v0 = lfsr[7:0];
			@(posedge aclk) pin_in <= v0;
			repeat (6) @(posedge aclk);
			rd(ppeiu_pkg::OFF_EVENT_FLAGS, 32'h0, ppeiu_pkg::RESP_OKAY);
			lfsr = nxt(lfsr);
			s = lfsr;
			lfsr = nxt(lfsr);
			v1 = lfsr[7:0];
			set_sel(s);
			@(posedge aclk) pm_clear <= 1'b1;
			@(posedge aclk) {pm_clear, pin_in} <= {1'b0, v1};
			repeat (6) @(negedge aclk);
			e = want(s, v0, v1);
			check("irq", port_combined_irq, {31'h0, |e});
			check("pm_wake", pm_wake, {31'h0, |e});
			rd(ppeiu_pkg::OFF_EVENT_FLAGS, {24'h0, e}, ppeiu_pkg::RESP_OKAY);
			rd(ppeiu_pkg::OFF_SNAPSHOT, {24'h0, v1}, ppeiu_pkg::RESP_OKAY);
			rd(ppeiu_pkg::OFF_PIN_LEVEL, {24'h0, v1}, ppeiu_pkg::RESP_OKAY);
			repeat (2) @(negedge aclk);
			check("irq", port_combined_irq, 32'h0);
			rd(ppeiu_pkg::OFF_EVENT_FLAGS, 32'h0, ppeiu_pkg::RESP_OKAY);
			set_sel(16'h0);
		end
		// edges landing in the very cycle that the flag read is taken
		set_sel(16'hFFFF);
		@(posedge aclk) pin_in <= pin_in ^ 8'h0F;
		repeat (6) @(posedge aclk);
		@(posedge aclk) pin_in <= pin_in ^ 8'hFF;
		@(posedge aclk);
		rd(ppeiu_pkg::OFF_EVENT_FLAGS, 32'h0F, ppeiu_pkg::RESP_OKAY);
		rd(ppeiu_pkg::OFF_EVENT_FLAGS, 32'hF0, ppeiu_pkg::RESP_OKAY);
		rd(ppeiu_pkg::OFF_EVENT_FLAGS, 32'h0, ppeiu_pkg::RESP_OKAY);
		repeat (4) @(posedge aclk);
		test_done();
	end
endmodule
`default_nettype wire
